// ---- include/imudsr_pkg.sv ----
// Package: register map, field layouts and reset values of the sample/status bank
package imudsr_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_ACCEL_X_LOW = 8'h00;
  localparam logic [7:0] OFF_RATE_X_LOW = 8'h06;
  localparam logic [7:0] OFF_TEMPERATURE_LOW = 8'h0c;
  localparam logic [7:0] OFF_TEMPERATURE_HIGH = 8'h0d;
  localparam logic [7:0] OFF_PART_IDENTIFIER = 8'h0f;
  localparam logic [7:0] OFF_MOTION_EVENT_FLAGS = 8'h10;
  localparam logic [7:0] OFF_DATA_FIFO_EVENT_FLAGS = 8'h11;
  localparam logic [7:0] OFF_HIGH_LOW_ACCEL_FLAGS = 8'h12;
  localparam logic [7:0] OFF_ACTIVITY_TAP_DETAIL = 8'h14;
  localparam logic [7:0] OFF_ORIENTATION_RESULT = 8'h15;
  localparam logic [7:0] OFF_QUEUE_COUNT_LOW = 8'h16;
  localparam logic [7:0] OFF_QUEUE_COUNT_HIGH_FLAGS = 8'h17;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int POS_HIGH_SIGN = 7;
  localparam int POS_LOW_G = 0;
  localparam int POS_VERTICAL = 2;
  localparam int POS_WATERMARK = 5;
  localparam int POS_FULL = 4;
  localparam int POS_EMPTY = 3;

  // ----------------------------------------
  // Reset values and identity
  // ----------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_SAMPLE = 16'h0000;
  localparam logic [11:0] RST_TEMP = 12'h000;
  localparam logic [10:0] RST_COUNT = 11'h000;
  localparam logic [1:0] RST_PLANAR = 2'h0;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
  // Arbitrary neutral identifier value
  localparam logic [7:0] PART_ID_VALUE = 8'h5a;

  // Planar orientation codes
  typedef enum logic [1:0] {
    IMUDSR_LAND_LEFT = 2'b00,
    IMUDSR_LAND_RIGHT = 2'b01,
    IMUDSR_PORT_DOWN = 2'b10,
    IMUDSR_PORT_UP = 2'b11
  } imudsr_planar_t;

  // Sign plus per-axis trigger record
  typedef struct packed {
    logic neg;
    logic x;
    logic y;
    logic z;
  } imudsr_axis_t;

  // Sample group from the sensing path
  typedef struct packed {
    logic [15:0] ax;
    logic [15:0] ay;
    logic [15:0] az;
    logic [15:0] gx;
    logic [15:0] gy;
    logic [15:0] gz;
    logic [11:0] temp;
  } imudsr_sample_t;

  // FIFO state from the queue
  typedef struct packed {
    logic [10:0] count;
    logic watermark;
    logic full;
    logic empty;
  } imudsr_fifo_t;

endpackage

// ---- rtl/imudsr_bank.sv ----
// Read-only sample, status and FIFO-state register bank of the inertial sensor
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Accel X/Y/Z low/high pairs from 0x00
// - Gyro X/Y/Z pairs at 0x06 to 0x0B
// - 12-bit temperature, high nibble in 0x0D
// - Fixed part identifier byte at 0x0F
// - Eight motion event flags in 0x10
// - Data ready and watermark flags in 0x11
// - High-g sign and axis in 0x12[7:4]
// - Low-g flag in 0x12 bit 0
// - Activity sign/axes in 0x14[7:4]
// - Tap sign/axes in 0x14[3:0]
// - Vertical orientation in 0x15 bit 2
// - Planar orientation code in 0x15[1:0]
// - 11-bit FIFO count over 0x16/0x17
// - Watermark, full, empty flags in 0x17
// - Address auto-increments during multi-byte transfers
module imudsr_bank (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Serial interface byte port
  input wire logic xfer_active,
  input wire logic addr_load,
  input wire logic [7:0] addr_in,
  input wire logic byte_done,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic [7:0] cur_addr,
  // Sensing path updates
  input wire logic sample_valid,
  input wire imudsr_pkg::imudsr_sample_t sample_in,
  // Event sources, one-cycle pulses from the detectors
  input wire logic [7:0] motion_set,
  input wire logic [7:0] motion_clr,
  input wire logic [3:0] data_set,
  input wire logic [3:0] data_clr,
  input wire logic high_g_set,
  input wire imudsr_pkg::imudsr_axis_t high_g_axis,
  input wire logic low_g_set,
  input wire logic status2_clr,
  input wire logic act_set,
  input wire imudsr_pkg::imudsr_axis_t act_axis,
  input wire logic tap_set,
  input wire imudsr_pkg::imudsr_axis_t tap_axis,
  input wire logic orient_valid,
  input wire logic orient_down,
  input wire imudsr_pkg::imudsr_planar_t orient_planar,
  // FIFO state
  input wire imudsr_pkg::imudsr_fifo_t fifo_in
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Sample group, loaded whole
  imudsr_pkg::imudsr_sample_t sample;
  // Event status
  logic [7:0] motion_flags;
  logic [3:0] data_flags;
  imudsr_pkg::imudsr_axis_t high_g;
  logic low_g;
  imudsr_pkg::imudsr_axis_t act_detail;
  imudsr_pkg::imudsr_axis_t tap_detail;
  logic vertical;
  imudsr_pkg::imudsr_planar_t planar;
  // Queue state mirror
  imudsr_pkg::imudsr_fifo_t fifo_state;
  // Read path
  logic [7:0] next_rd_data;
  // Assembled status bytes, reserved bits zero
  logic [7:0] temp_high_byte;
  logic [7:0] data_byte;
  logic [7:0] high_low_byte;
  logic [7:0] detail_byte;
  logic [7:0] orient_byte;
  logic [7:0] queue_high_byte;

  // Sticky update: a set in the same cycle as a clear wins
  function automatic logic [7:0] sticky8(input logic [7:0] cur, input logic [7:0] set, input logic [7:0] clr);
    sticky8 = (cur & ~clr) | set;
  endfunction

  // Same set-wins rule for the four data flags
  function automatic logic [3:0] sticky4(input logic [3:0] cur, input logic [3:0] set, input logic [3:0] clr);
    sticky4 = (cur & ~clr) | set;
  endfunction

  // Low byte of a sample, read at the even address
  function automatic logic [7:0] low_of(input logic [15:0] v);
    low_of = v[7:0];
  endfunction

  // High byte of a sample, read at the odd address
  function automatic logic [7:0] high_of(input logic [15:0] v);
    high_of = v[15:8];
  endfunction

  // ----------------------------------------
  // Samples
  // ----------------------------------------
  // Whole group loads at once so a burst reads a coherent low/high pair
  // Limitation: a load between the two bytes of one pair still tears it
  // Samples have no defined reset value; zero keeps early reads known
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sample <= '{
        ax: imudsr_pkg::RST_SAMPLE,
        ay: imudsr_pkg::RST_SAMPLE,
        az: imudsr_pkg::RST_SAMPLE,
        gx: imudsr_pkg::RST_SAMPLE,
        gy: imudsr_pkg::RST_SAMPLE,
        gz: imudsr_pkg::RST_SAMPLE,
        temp: imudsr_pkg::RST_TEMP
      };
    end else if (sample_valid) begin
      sample <= sample_in;
    end
  end

  // ----------------------------------------
  // Event status
  // ----------------------------------------
  // Motion event flags
  // Clears come from outside; clear-on-read lives with the host side
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      motion_flags <= imudsr_pkg::RST_BYTE;
    end else begin
      motion_flags <= sticky8(motion_flags, motion_set, motion_clr);
    end
  end

  // Data ready and watermark flags
  // A ready pulse in the clearing cycle is kept, never lost
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_flags <= imudsr_pkg::RST_BYTE[3:0];
    end else begin
      data_flags <= sticky4(data_flags, data_set, data_clr);
    end
  end

  // ----------------------------------------
  // High and low acceleration
  // ----------------------------------------
  // High-g and low-g record; a new event overwrites the axis detail
  // Set is tested first, so an event in the clearing cycle survives
  // Sign stays with the axes that caused it, never mixed with older ones
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      high_g <= '0;
    end else if (high_g_set) begin
      high_g <= high_g_axis;
    end else if (status2_clr) begin
      high_g <= '0;
    end
  end

  // Low-g flag
  // Shares the clear with the high-g record, set again winning
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      low_g <= 1'b0;
    end else if (low_g_set) begin
      low_g <= 1'b1;
    end else if (status2_clr) begin
      low_g <= 1'b0;
    end
  end

  // ----------------------------------------
  // Activity and tap detail
  // ----------------------------------------
  // Activity/inactivity detail
  // No clear input: the last event's detail stays until the next one
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      act_detail <= '0;
    end else if (act_set) begin
      act_detail <= act_axis;
    end
  end

  // Tap detail
  // Shares the byte with the activity detail, lower nibble
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tap_detail <= '0;
    end else if (tap_set) begin
      tap_detail <= tap_axis;
    end
  end

  // ----------------------------------------
  // Orientation
  // ----------------------------------------
  // Orientation result
  // Both fields load together so a read never mixes two results
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      vertical <= 1'b0;
      planar <= imudsr_pkg::IMUDSR_LAND_LEFT;
    end else if (orient_valid) begin
      vertical <= orient_down;
      planar <= orient_planar;
    end
  end

  // ----------------------------------------
  // Queue state
  // ----------------------------------------
  // FIFO state mirror, registered so a read sees a settled value
  // Costs one cycle of staleness on the count and flags
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fifo_state <= '{count: imudsr_pkg::RST_COUNT, default: 1'b0};
    end else begin
      fifo_state <= fifo_in;
    end
  end

  // ----------------------------------------
  // Address pointer
  // ----------------------------------------
  // Loads on the start address, steps after each byte within one transfer
  // A load wins over a step, so a reload mid-burst restarts cleanly
  // The pointer wraps from the top address back to zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur_addr <= imudsr_pkg::OFF_ACCEL_X_LOW;
    end else if (addr_load) begin
      cur_addr <= addr_in;
    end else if (xfer_active && byte_done) begin
      cur_addr <= cur_addr + 8'h01;
    end
  end

  // ----------------------------------------
  // Byte assembly
  // ----------------------------------------
  // Mixed-field bytes built on a zero base so reserved bits stay low
  always_comb begin
    // Temperature upper nibble
    temp_high_byte = imudsr_pkg::RST_BYTE;
    temp_high_byte[3:0] = sample.temp[11:8];
    // Data ready and watermark flags
    data_byte = imudsr_pkg::RST_BYTE;
    data_byte[3:0] = data_flags;
    // High-g record and low-g flag
    high_low_byte = imudsr_pkg::RST_BYTE;
    high_low_byte[imudsr_pkg::POS_HIGH_SIGN -: 4] = high_g;
    high_low_byte[imudsr_pkg::POS_LOW_G] = low_g;
    // Activity detail above tap detail
    detail_byte = {act_detail, tap_detail};
    // Orientation result
    orient_byte = imudsr_pkg::RST_BYTE;
    orient_byte[imudsr_pkg::POS_VERTICAL] = vertical;
    orient_byte[1:0] = planar;
    // Queue flags over the count's upper bits
    queue_high_byte = imudsr_pkg::RST_BYTE;
    queue_high_byte[imudsr_pkg::POS_WATERMARK] = fifo_state.watermark;
    queue_high_byte[imudsr_pkg::POS_FULL] = fifo_state.full;
    queue_high_byte[imudsr_pkg::POS_EMPTY] = fifo_state.empty;
    queue_high_byte[2:0] = fifo_state.count[10:8];
  end

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  // No write path exists: wr_en and wr_data reach no storage
  // Gaps in the map read as zero, like the reserved bits
  always_comb begin
    next_rd_data = imudsr_pkg::UNMAPPED_VALUE;
    // Accelerometer pairs, low byte first
    if (cur_addr == imudsr_pkg::OFF_ACCEL_X_LOW) begin
      next_rd_data = low_of(sample.ax);
    end else if (cur_addr == imudsr_pkg::OFF_ACCEL_X_LOW + 8'h01) begin
      next_rd_data = high_of(sample.ax);
    end else if (cur_addr == imudsr_pkg::OFF_ACCEL_X_LOW + 8'h02) begin
      next_rd_data = low_of(sample.ay);
    end else if (cur_addr == imudsr_pkg::OFF_ACCEL_X_LOW + 8'h03) begin
      next_rd_data = high_of(sample.ay);
    end else if (cur_addr == imudsr_pkg::OFF_ACCEL_X_LOW + 8'h04) begin
      next_rd_data = low_of(sample.az);
    end else if (cur_addr == imudsr_pkg::OFF_ACCEL_X_LOW + 8'h05) begin
      next_rd_data = high_of(sample.az);
    // Gyroscope pairs directly after
    end else if (cur_addr == imudsr_pkg::OFF_RATE_X_LOW) begin
      next_rd_data = low_of(sample.gx);
    end else if (cur_addr == imudsr_pkg::OFF_RATE_X_LOW + 8'h01) begin
      next_rd_data = high_of(sample.gx);
    end else if (cur_addr == imudsr_pkg::OFF_RATE_X_LOW + 8'h02) begin
      next_rd_data = low_of(sample.gy);
    end else if (cur_addr == imudsr_pkg::OFF_RATE_X_LOW + 8'h03) begin
      next_rd_data = high_of(sample.gy);
    end else if (cur_addr == imudsr_pkg::OFF_RATE_X_LOW + 8'h04) begin
      next_rd_data = low_of(sample.gz);
    end else if (cur_addr == imudsr_pkg::OFF_RATE_X_LOW + 8'h05) begin
      next_rd_data = high_of(sample.gz);
    // Temperature, twelve bits over two bytes
    end else if (cur_addr == imudsr_pkg::OFF_TEMPERATURE_LOW) begin
      next_rd_data = sample.temp[7:0];
    end else if (cur_addr == imudsr_pkg::OFF_TEMPERATURE_HIGH) begin
      next_rd_data = temp_high_byte;
    // Fixed identifier
    end else if (cur_addr == imudsr_pkg::OFF_PART_IDENTIFIER) begin
      next_rd_data = imudsr_pkg::PART_ID_VALUE;
    // Event status bytes
    end else if (cur_addr == imudsr_pkg::OFF_MOTION_EVENT_FLAGS) begin
      next_rd_data = motion_flags;
    end else if (cur_addr == imudsr_pkg::OFF_DATA_FIFO_EVENT_FLAGS) begin
      next_rd_data = data_byte;
    end else if (cur_addr == imudsr_pkg::OFF_HIGH_LOW_ACCEL_FLAGS) begin
      next_rd_data = high_low_byte;
    end else if (cur_addr == imudsr_pkg::OFF_ACTIVITY_TAP_DETAIL) begin
      next_rd_data = detail_byte;
    end else if (cur_addr == imudsr_pkg::OFF_ORIENTATION_RESULT) begin
      next_rd_data = orient_byte;
    // Queue count and flags
    end else if (cur_addr == imudsr_pkg::OFF_QUEUE_COUNT_LOW) begin
      next_rd_data = fifo_state.count[7:0];
    end else if (cur_addr == imudsr_pkg::OFF_QUEUE_COUNT_HIGH_FLAGS) begin
      next_rd_data = queue_high_byte;
    end
  end

  // Read byte register, one cycle behind the pointer
  // Registered so rd_data never glitches while the pointer steps
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data <= imudsr_pkg::RST_BYTE;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule // imudsr_bank
`default_nettype wire

// ---- bench/imudsr_asserts.sv ----
// Checker for pointer behaviour, read latency and fixed fields of the bank
`timescale 1ns/1ps
`default_nettype none
module imudsr_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Byte port
  input wire logic xfer_active,
  input wire logic addr_load,
  input wire logic [7:0] addr_in,
  input wire logic byte_done,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] cur_addr,
  // FIFO state
  input wire imudsr_pkg::imudsr_fifo_t fifo_in
);
  // One domain; reset disables every check
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  addr_load_a: assert property (addr_load |=> cur_addr == $past(addr_in))
    else $error("start address not taken");
  addr_step_a: assert property (byte_done && xfer_active && !addr_load |=> cur_addr == $past(cur_addr) + 8'h01)
    else $error("pointer did not advance by one");
  part_id_a: assert property (cur_addr == 8'h0f |=> rd_data == imudsr_pkg::PART_ID_VALUE)
    else $error("identifier byte wrong");
  temp_rsvd_a: assert property (cur_addr == 8'h0d |=> rd_data[7:4] == 4'h0)
    else $error("temperature high nibble not zero");
  accel_rsvd_a: assert property (cur_addr == 8'h12 |=> rd_data[3:1] == 3'h0)
    else $error("reserved accel flag bits set");
  orient_rsvd_a: assert property (cur_addr == 8'h15 |=> rd_data[7:3] == 5'h00)
    else $error("reserved orientation bits set");
  // FIFO state passes a mirror register, hence two cycles back
  count_low_a: assert property (!$past(rst) && cur_addr == 8'h16 |=> rd_data == $past(fifo_in.count[7:0], 2))
    else $error("count low byte wrong");
  fifo_high_a: assert property (!$past(rst) && cur_addr == 8'h17 |=>
    rd_data == {2'b00, $past({fifo_in.watermark, fifo_in.full, fifo_in.empty, fifo_in.count[10:8]}, 2)})
    else $error("fifo flag byte wrong");
endmodule // imudsr_asserts

bind imudsr_bank imudsr_asserts chk_u (
  .clk_sys, .rst, .xfer_active, .addr_load, .addr_in, .byte_done, .rd_data, .cur_addr, .fifo_in
);
`default_nettype wire

// ---- bench/imudsr_host.sv ----
// Host model: loads a start address, then clocks bytes out of the bank
`timescale 1ns/1ps
`default_nettype none
module imudsr_host (
  // Clock
  input wire logic clk_sys,
  // Byte port towards the bank
  input wire logic [7:0] rd_data,
  output logic xfer_active,
  output logic addr_load,
  output logic [7:0] addr_in,
  output logic byte_done,
  output logic wr_en,
  output logic [7:0] wr_data
);
  logic [7:0] got [$];

  // Idle levels at time zero
  initial begin
    {xfer_active, addr_load, addr_in, byte_done, wr_en, wr_data} = '0;
  end

  // Released address shows its inverse so a stale value is never trusted
  task automatic start(input logic [7:0] a);
    @(posedge clk_sys);
    xfer_active <= 1'b1;
    addr_load <= 1'b1;
    addr_in <= a;
    @(posedge clk_sys);
    addr_load <= 1'b0;
    addr_in <= ~a;
  endtask

  // Transfer stays active for the whole burst; gap models a slow host
  task automatic burst(input logic [7:0] a, input int n, input int gap);
    got.delete();
    start(a);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      byte_done <= 1'b1;
      @(negedge clk_sys);
      got.push_back(rd_data);
      @(posedge clk_sys);
      byte_done <= 1'b0;
      repeat (gap) @(posedge clk_sys);
    end
    xfer_active <= 1'b0;
  endtask

  // Single byte write, which the bank must ignore
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start(a);
    wr_en <= 1'b1;
    wr_data <= d;
    byte_done <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    wr_data <= ~d;
    byte_done <= 1'b0;
    xfer_active <= 1'b0;
  endtask
endmodule // imudsr_host
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the sample and status register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic xfer_active, addr_load, byte_done, wr_en, sample_valid, high_g_set, low_g_set;
  logic status2_clr, act_set, tap_set, orient_valid, orient_down;
  logic [7:0] addr_in, wr_data, rd_data, cur_addr, motion_set, motion_clr;
  logic [3:0] data_set, data_clr;
  imudsr_pkg::imudsr_sample_t sample_in;
  imudsr_pkg::imudsr_axis_t high_g_axis, act_axis, tap_axis;
  imudsr_pkg::imudsr_planar_t orient_planar;
  imudsr_pkg::imudsr_fifo_t fifo_in;
  int fails = 0;
  int compares = 0;

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  imudsr_bank dut_u (.clk_sys, .rst, .xfer_active, .addr_load, .addr_in, .byte_done, .wr_en, .wr_data,
    .rd_data, .cur_addr, .sample_valid, .sample_in, .motion_set, .motion_clr, .data_set, .data_clr,
    .high_g_set, .high_g_axis, .low_g_set, .status2_clr, .act_set, .act_axis, .tap_set, .tap_axis,
    .orient_valid, .orient_down, .orient_planar, .fifo_in);
  imudsr_host host_u (.clk_sys, .rd_data, .xfer_active, .addr_load, .addr_in, .byte_done, .wr_en, .wr_data);

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic reset_values();
    host_u.burst(8'h00, 24, 0);
    for (int i = 0; i < 24; i++) begin
      check("reset byte", (i == 15) ? imudsr_pkg::PART_ID_VALUE : 8'h00, host_u.got[i]);
    end
  endtask

  // Input changes after the load strobe must not leak into the bank
  task automatic samples();
    @(posedge clk_sys);
    sample_in <= {16'h1110, 16'h1312, 16'h1514, 16'h1716, 16'h1918, 16'h1b1a, 12'hd1c};
    sample_valid <= 1'b1;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    sample_in <= ~sample_in;
    host_u.burst(8'h00, 14, 1);
    for (int i = 0; i < 14; i++) begin
      check("sample byte", (i == 13) ? 8'h0d : 8'h10 + 8'(i), host_u.got[i]);
    end
  endtask

  task automatic events();
    logic [7:0] e [8] = '{8'ha5, 8'h09, 8'hb1, 8'h00, 8'h69, 8'h06, 8'hc3, 8'h2d};
    @(posedge clk_sys);
    {motion_set, data_set, high_g_set, high_g_axis, low_g_set} <= {8'ha5, 4'h9, 1'b1, 4'hb, 1'b1};
    {act_set, act_axis, tap_set, tap_axis, orient_valid, orient_down} <= {1'b1, 4'h6, 1'b1, 4'h9, 2'b11};
    orient_planar <= imudsr_pkg::IMUDSR_PORT_DOWN;
    fifo_in <= {11'h5c3, 3'b101};
    @(posedge clk_sys);
    {motion_set, data_set, high_g_set, low_g_set, act_set, tap_set, orient_valid} <= '0;
    host_u.burst(8'h10, 8, 0);
    for (int i = 0; i < 8; i++) begin
      check("status byte", e[i], host_u.got[i]);
    end
  endtask

  // Every planar code once, with the motion, data and high/low-g flags cleared at the same time
  task automatic clears_and_codes();
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_sys);
      {motion_clr, data_clr, status2_clr, orient_valid, orient_down} <= {8'hff, 4'hf, 3'b110};
      orient_planar <= imudsr_pkg::imudsr_planar_t'(c);
      @(posedge clk_sys);
      {motion_clr, data_clr, status2_clr, orient_valid} <= '0;
      host_u.burst(8'h10, 6, 0);
      check("cleared flags", 8'h00, host_u.got[0] | host_u.got[1] | host_u.got[2]);
      check("planar code", 8'(c), host_u.got[5]);
    end
  endtask

  // Writes are dropped; the pointer wraps from the top address
  task automatic writes_ignored();
    host_u.wr(8'h00, 8'hee);
    host_u.wr(8'h0f, 8'h00);
    host_u.burst(8'hff, 17, 0);
    check("unmapped byte", 8'h00, host_u.got[0]);
    check("wrapped byte", 8'h10, host_u.got[1]);
    check("identifier", imudsr_pkg::PART_ID_VALUE, host_u.got[16]);
  endtask

  // Main sequence
  initial begin
    {sample_valid, sample_in, motion_set, motion_clr, data_set, data_clr, high_g_set, high_g_axis} = '0;
    {low_g_set, status2_clr, act_set, act_axis, tap_set, tap_axis} = '0;
    {orient_valid, orient_down, orient_planar, fifo_in} = '0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    reset_values();
    samples();
    events();
    clears_and_codes();
    writes_ignored();
    report_and_stop();
  end

  // Watchdog, well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
